// File: hw/pll_serial_pkg.sv
`default_nettype none
package pll_serial_pkg;
  // Serial word geometry
  localparam int WORD_BITS = 24;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 1;
  // Latch codes carried in the two low word bits
  localparam logic [1:0] SEL_IF_REF = 2'h0;
  localparam logic [1:0] SEL_IF_DIV = 2'h1;
  localparam logic [1:0] SEL_RF_REF = 2'h2;
  localparam logic [1:0] SEL_RF_DIV = 2'h3;
  // Radio reference latch fields
  localparam int RREF_TRI_POS = 18;
  localparam int RREF_CUR_LSB = 21;
  localparam int RREF_CUR_MSB = 23;
  // Radio divide latch fields
  localparam int RDIV_SWALLOW_LSB = 2;
  localparam int RDIV_SWALLOW_MSB = 7;
  localparam int RDIV_MAIN_LSB = 8;
  localparam int RDIV_MAIN_MSB = 19;
  localparam int RDIV_PRESC_LSB = 20;
  localparam int RDIV_PRESC_MSB = 21;
  localparam int RDIV_PD_POS = 22;
  localparam int RDIV_GAIN_POS = 23;
  // Reset value, maximum pump current and all-loaded mask
  localparam logic [23:0] WORD_RESET = 24'h000000;
  localparam logic [2:0] CUR_MAX = 3'h7;
  localparam logic [3:0] LOADED_ALL = 4'hF;
endpackage
`default_nettype wire

// File: hw/link_edge_sync.sv
`default_nettype none
// Two-flop synchroniser with rising-edge detect for one pin
module link_edge_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Pin and results
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // Only the second stage and later are looked at, to avoid metastable reads
  always_comb begin
    next_meta = pin;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level = sync;
  assign rise = sync & ~prev;
endmodule
`default_nettype wire

// File: hw/pll_serial_latch_rf_control.sv
`default_nettype none
// Contract
// - Tri-state bit 1 places radio pump output in high impedance.
// - Three-bit current field selects radio pump current level.
// - Select code 11 loads payload into radio divide latch.
// - Divide value built from 6-bit swallow and 12-bit main counts.
// - Two divide-latch bits select radio prescaler ratio.
// - Gain bit in divide latch enables fast lock while 1.
// - Fast lock forces pump current to maximum.
// - Fast lock drives switch pin to ground damping resistor.
// - One divide write applies counts and starts fast lock together.
// - One data bit shifted in per rising serial clock edge.
// - Strobe rising copies shift register into selected latch.
// - Pump tri-state, power-down and switch pin stay inactive until all four latches loaded; counts and current follow earlier.
// - Codes 00, 01, 10 route to other three latches.
// - Power-down: tri-state first if pump active, else immediate.
module pll_serial_latch_rf_control
  import pll_serial_pkg::*;
#(
  parameter int SWALLOW_BITS = 6,
  parameter int MAIN_BITS = 12
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Serial pins
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadStrobe,
  // Radio divider controls
  output logic [SWALLOW_BITS-1:0] rfSwallowCount,
  output logic [MAIN_BITS-1:0] rfMainCount,
  output logic [1:0] rfPrescaleSel,
  // Radio pump and power
  output logic rfPumpTristate,
  output logic [2:0] rfPumpCurrent,
  output logic rfPowerdown,
  output logic fastLockSwitchPin,
  // Other latches, raw payload, and the all-loaded flag
  output logic [WORD_BITS-1:0] ifRefWord,
  output logic [WORD_BITS-1:0] ifDivWord,
  output logic outputsActive
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic clkRise;
  logic dataLevel;
  logic strobeRise;

  // Clock and strobe only need their edges, data only its level
  link_edge_sync clkSync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(serialClk),
    .level(),
    .rise(clkRise)
  );
  link_edge_sync dataSync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(serialData),
    .level(dataLevel),
    .rise()
  );
  link_edge_sync strobeSync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(loadStrobe),
    .level(),
    .rise(strobeRise)
  );

  // ****************************************
  // Shift register and latches
  // ****************************************
  logic [WORD_BITS-1:0] shiftWord;
  logic [WORD_BITS-1:0] rfRefWord;
  logic [WORD_BITS-1:0] rfDivWord;
  logic [3:0] loaded;
  logic [WORD_BITS-1:0] next_shiftWord;
  logic [WORD_BITS-1:0] next_ifRefWord;
  logic [WORD_BITS-1:0] next_ifDivWord;
  logic [WORD_BITS-1:0] next_rfRefWord;
  logic [WORD_BITS-1:0] next_rfDivWord;
  logic [3:0] next_loaded;
  logic [1:0] sel;

  // Data and clock share the same sync depth, so data is sampled aligned with the edge
  always_comb begin
    next_shiftWord = shiftWord;
    next_ifRefWord = ifRefWord;
    next_ifDivWord = ifDivWord;
    next_rfRefWord = rfRefWord;
    next_rfDivWord = rfDivWord;
    next_loaded = loaded;
    sel = shiftWord[SEL_MSB:SEL_LSB];
    if (clkRise) begin
      next_shiftWord = {shiftWord[WORD_BITS-2:0], dataLevel};
    end
    if (strobeRise) begin
      next_loaded[sel] = 1'b1;
      if (sel == SEL_IF_REF) begin
        next_ifRefWord = shiftWord;
      end else if (sel == SEL_IF_DIV) begin
        next_ifDivWord = shiftWord;
      end else if (sel == SEL_RF_REF) begin
        next_rfRefWord = shiftWord;
      end else begin
        next_rfDivWord = shiftWord;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      shiftWord <= WORD_RESET;
      ifRefWord <= WORD_RESET;
      ifDivWord <= WORD_RESET;
      rfRefWord <= WORD_RESET;
      rfDivWord <= WORD_RESET;
      loaded <= 4'h0;
    end else begin
      shiftWord <= next_shiftWord;
      ifRefWord <= next_ifRefWord;
      ifDivWord <= next_ifDivWord;
      rfRefWord <= next_rfRefWord;
      rfDivWord <= next_rfDivWord;
      loaded <= next_loaded;
    end
  end

  // ****************************************
  // Radio output stage
  // ****************************************
  logic active;
  logic fastLock;
  logic pdReq;
  logic pdAsync;
  logic next_rfPowerdown;
  logic next_rfPumpTristate;
  logic [2:0] next_rfPumpCurrent;
  logic next_fastLockSwitchPin;
  logic [SWALLOW_BITS-1:0] next_rfSwallowCount;
  logic [MAIN_BITS-1:0] next_rfMainCount;
  logic [1:0] next_rfPrescaleSel;
  logic next_outputsActive;

  // Outputs held inactive (pump off, powered down) until every latch was written
  always_comb begin
    active = (loaded == LOADED_ALL);
    fastLock = rfDivWord[RDIV_GAIN_POS];
    pdReq = rfDivWord[RDIV_PD_POS];
    pdAsync = rfRefWord[RREF_TRI_POS];
    next_outputsActive = active;
    next_rfSwallowCount = rfDivWord[RDIV_SWALLOW_MSB:RDIV_SWALLOW_LSB];
    next_rfMainCount = rfDivWord[RDIV_MAIN_MSB:RDIV_MAIN_LSB];
    next_rfPrescaleSel = rfDivWord[RDIV_PRESC_MSB:RDIV_PRESC_LSB];
    next_rfPumpCurrent = fastLock ? CUR_MAX : rfRefWord[RREF_CUR_MSB:RREF_CUR_LSB];
    next_fastLockSwitchPin = active & fastLock;
    // Synchronous path tri-states the pump one cycle before the section drops
    next_rfPumpTristate = !active | pdAsync | pdReq;
    next_rfPowerdown = !active | (pdReq & (pdAsync | rfPumpTristate));
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rfSwallowCount <= '0;
      rfMainCount <= '0;
      rfPrescaleSel <= 2'h0;
      rfPumpCurrent <= 3'h0;
      fastLockSwitchPin <= 1'b0;
      rfPumpTristate <= 1'b1;
      rfPowerdown <= 1'b1;
      outputsActive <= 1'b0;
    end else begin
      rfSwallowCount <= next_rfSwallowCount;
      rfMainCount <= next_rfMainCount;
      rfPrescaleSel <= next_rfPrescaleSel;
      rfPumpCurrent <= next_rfPumpCurrent;
      fastLockSwitchPin <= next_fastLockSwitchPin;
      rfPumpTristate <= next_rfPumpTristate;
      rfPowerdown <= next_rfPowerdown;
      outputsActive <= next_outputsActive;
    end
  end

  // ****************************************
  // Check helpers
  // ****************************************
  logic [4:0] edgeCount;
  logic [4:0] next_edgeCount;

  // Serial edges since the last strobe; saturates so an overlong frame cannot wrap back to 24
  always_comb begin
    next_edgeCount = edgeCount;
    if (strobeRise) begin
      next_edgeCount = 5'h00;
    end else if (clkRise && edgeCount != 5'h1F) begin
      next_edgeCount = edgeCount + 5'h01;
    end
  end

  // Read only by the checks; no output depends on it, so synthesis drops it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      edgeCount <= 5'h00;
    end else begin
      edgeCount <= next_edgeCount;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // One clock domain, so one default clock serves every check and one default reset every check but a_reset_state
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Shift, radio latch loads, counts, fast lock and power ordering
  a_shift_one_bit: assert property (clkRise |=> shiftWord == {$past(shiftWord[WORD_BITS-2:0]), $past(dataLevel)})
    else $error("shift register did not take one bit");
  a_rfdiv_load: assert property (strobeRise && shiftWord[1:0] == SEL_RF_DIV |=> rfDivWord == $past(shiftWord))
    else $error("radio divide latch not loaded");
  a_rfref_load: assert property (strobeRise && shiftWord[1:0] == SEL_RF_REF |=> rfRefWord == $past(shiftWord))
    else $error("radio reference latch not loaded");
  a_counts_follow: assert property (##1 rfMainCount == $past(rfDivWord[RDIV_MAIN_MSB:RDIV_MAIN_LSB]))
    else $error("main count does not follow latch");
  a_fast_current: assert property (rfDivWord[RDIV_GAIN_POS] |=> rfPumpCurrent == CUR_MAX)
    else $error("fast lock current not maximum");
  a_fast_pin: assert property (active && rfDivWord[RDIV_GAIN_POS] |=> fastLockSwitchPin)
    else $error("fast lock pin not driven");
  a_tristate_out: assert property (rfRefWord[RREF_TRI_POS] |=> rfPumpTristate)
    else $error("pump not tri-stated");
  a_inactive_early: assert property (loaded != LOADED_ALL |=> !outputsActive && rfPowerdown)
    else $error("outputs active before four loads");
  a_sync_pd_order: assert property ($rose(rfPowerdown) && active |-> $past(rfPumpTristate))
    else $error("power-down before pump tri-state");

  // IF latch loads; idle serial clock and absent strobe must leave state untouched
  a_shift_hold: assert property (!clkRise |=> $stable(shiftWord))
    else $error("shift register moved without a serial edge");
  a_ifref_load: assert property (strobeRise && sel == SEL_IF_REF |=> ifRefWord == $past(shiftWord))
    else $error("IF reference latch not loaded");
  a_ifdiv_load: assert property (strobeRise && sel == SEL_IF_DIV |=> ifDivWord == $past(shiftWord))
    else $error("IF divide latch not loaded");
  a_radio_hold: assert property (!strobeRise |=> $stable(rfDivWord) && $stable(rfRefWord))
    else $error("radio latch changed without a strobe");
  a_if_hold: assert property (!strobeRise |=> $stable(ifRefWord) && $stable(ifDivWord))
    else $error("IF latch changed without a strobe");

  // Divider fields are copied from the divide latch one cycle later
  a_swallow_follow: assert property (
    ##1 rfSwallowCount == $past(rfDivWord[RDIV_SWALLOW_MSB:RDIV_SWALLOW_LSB]))
    else $error("swallow count does not follow latch");
  a_prescale_follow: assert property (
    ##1 rfPrescaleSel == $past(rfDivWord[RDIV_PRESC_MSB:RDIV_PRESC_LSB]))
    else $error("prescaler select does not follow latch");

  // Switch pin and pump current answer to the gain bit, and the pin never before all four latches are loaded
  a_pin_needs_gain: assert property (
    fastLockSwitchPin |-> $past(rfDivWord[RDIV_GAIN_POS]) && $past(active))
    else $error("fast lock pin without gain bit");
  a_fast_release: assert property (!active |=> !fastLockSwitchPin)
    else $error("fast lock pin before four loads");
  a_normal_current: assert property (
    !rfDivWord[RDIV_GAIN_POS] |=> rfPumpCurrent == $past(rfRefWord[RREF_CUR_MSB:RREF_CUR_LSB]))
    else $error("pump current does not follow field");
  a_one_write: assert property (
    strobeRise && sel == SEL_RF_DIV && shiftWord[RDIV_GAIN_POS] && active
    |=> ##1 fastLockSwitchPin && rfMainCount == $past(shiftWord[RDIV_MAIN_MSB:RDIV_MAIN_LSB], 2))
    else $error("divide write did not apply counts and fast lock");

  // Pump and power sequencing once the outputs are live, and the reset state
  a_pump_normal: assert property (
    active && !rfRefWord[RREF_TRI_POS] && !rfDivWord[RDIV_PD_POS] |=> !rfPumpTristate)
    else $error("pump tri-stated in normal operation");
  a_async_pd_now: assert property (
    active && rfRefWord[RREF_TRI_POS] && rfDivWord[RDIV_PD_POS] |=> rfPowerdown)
    else $error("asynchronous power-down late");
  a_sync_pd_wait: assert property (
    active && !rfRefWord[RREF_TRI_POS] && !rfPumpTristate && rfDivWord[RDIV_PD_POS]
    |=> !rfPowerdown ##1 rfPowerdown)
    else $error("synchronous power-down out of order");
  a_pd_release: assert property (active && !rfDivWord[RDIV_PD_POS] |=> !rfPowerdown)
    else $error("radio not powered up after clear");
  a_active_sticky: assert property (outputsActive |=> outputsActive)
    else $error("outputs fell back to inactive");
  a_reset_state: assert property (
    disable iff (1'b0) !nrst |=> rfPumpTristate && rfPowerdown && !outputsActive && !fastLockSwitchPin)
    else $error("reset did not park the radio outputs");

  // Main scenarios: divide write, full power-up, fast lock, synchronous power-down, overlong frame
  c_rfdiv_write: cover property (strobeRise && shiftWord[1:0] == SEL_RF_DIV);
  c_all_loaded: cover property ($rose(outputsActive));
  c_fast_lock: cover property ($rose(fastLockSwitchPin));
  c_sync_powerdown: cover property (active && !rfPumpTristate ##1 rfPumpTristate && !rfPowerdown ##1 rfPowerdown);
  c_long_frame: cover property (strobeRise && edgeCount > WORD_BITS);
endmodule
`default_nettype wire

// File: sim/serial_host_model.sv
`default_nettype none
// ****************************************
// Host controller driving the write port
// ****************************************
module serial_host_model (
  // Serial pins
  output logic serialClk,
  output logic serialData,
  output logic loadStrobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock stands low between frames, strobe idles low
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    loadStrobe = 1'b0;
  end
  // Filler bits first, then the word MSB first; 125 ns period keeps under 20 MHz
  task automatic send_word(input logic [23:0] w, input int pre);
    loadStrobe = 1'b0;
    for (int i = 23 + pre; i >= 0; i--) begin
      serialData = (i > 23) ? i[0] : w[i];
      #62.5 serialClk = 1'b1;
      #62.5 serialClk = 1'b0;
    end
    // Released data line must not keep showing the last bit
    serialData = ~serialData;
    #62.5 loadStrobe = 1'b1;
    #62.5 loadStrobe = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: sim/test_pll_serial_latch_rf_control.sv
`default_nettype none
// ****************************************
// Self-checking bench for the serial latch block
// ****************************************
module test_pll_serial_latch_rf_control;
  timeunit 1ns;
  timeprecision 100ps;
  import pll_serial_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  wire logic serialClk, serialData, loadStrobe;
  logic [5:0] rfSwallowCount;
  logic [11:0] rfMainCount;
  logic [1:0] rfPrescaleSel;
  logic rfPumpTristate, rfPowerdown, fastLockSwitchPin, outputsActive;
  logic [2:0] rfPumpCurrent;
  logic [23:0] ifRefWord, ifDivWord;
  int miscompares = 0;
  int num_checks = 0;
  serial_host_model u_serial_host_model (.serialClk(serialClk), .serialData(serialData), .loadStrobe(loadStrobe));
  pll_serial_latch_rf_control u_pll_serial_latch_rf_control (.mclk(mclk), .nrst(nrst), .serialClk(serialClk),
    .serialData(serialData), .loadStrobe(loadStrobe), .rfSwallowCount(rfSwallowCount), .rfMainCount(rfMainCount),
    .rfPrescaleSel(rfPrescaleSel), .rfPumpTristate(rfPumpTristate), .rfPumpCurrent(rfPumpCurrent),
    .rfPowerdown(rfPowerdown), .fastLockSwitchPin(fastLockSwitchPin), .ifRefWord(ifRefWord),
    .ifDivWord(ifDivWord), .outputsActive(outputsActive));
  // 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Radio divide word: gain, power-down, prescale, main, swallow, select 11
  function automatic logic [23:0] div_word(logic g, logic p, logic [1:0] ps, logic [11:0] m, logic [5:0] s);
    return {g, p, ps, m, s, SEL_RF_DIV};
  endfunction
  // Compare any result up to a word wide
  task automatic compare(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Send one word and let the synchroniser and latch settle
  task automatic load(input logic [23:0] w, input int pre);
    u_serial_host_model.send_word(w, pre);
    repeat (10) @(negedge mclk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Outputs held inactive until all four latches written
  task automatic t_power_up();
    compare("tristate", 24'h1, rfPumpTristate);
    compare("powerdown", 24'h1, rfPowerdown);
    load(24'h5A5A5C, 0);
    load(24'h3C3C3D, 0);
    load(24'hA0004E, 0);
    compare("active3", 24'h0, outputsActive);
    load(div_word(1'b0, 1'b0, 2'h2, 12'hABC, 6'h15), 0);
    compare("active", 24'h1, outputsActive);
    compare("ifref", 24'h5A5A5C, ifRefWord);
    compare("ifdiv", 24'h3C3C3D, ifDivWord);
    compare("tristate", 24'h0, rfPumpTristate);
    compare("current", 24'h5, rfPumpCurrent);
    compare("swallow", 24'h15, rfSwallowCount);
    compare("main", 24'hABC, rfMainCount);
    compare("presc", 24'h2, rfPrescaleSel);
    compare("powerdown", 24'h0, rfPowerdown);
  endtask
  // One divide write sets counts and fast lock; a second with the gain bit clear ends it
  task automatic t_fast_lock();
    load(div_word(1'b1, 1'b0, 2'h1, 12'h0F3, 6'h2A), 0);
    compare("current", 24'h7, rfPumpCurrent);
    compare("flpin", 24'h1, fastLockSwitchPin);
    compare("main", 24'h0F3, rfMainCount);
    compare("swallow", 24'h2A, rfSwallowCount);
    load(div_word(1'b0, 1'b0, 2'h3, 12'hFFF, 6'h3F), 0);
    compare("current", 24'h5, rfPumpCurrent);
    compare("flpin", 24'h0, fastLockSwitchPin);
    compare("main", 24'hFFF, rfMainCount);
    compare("presc", 24'h3, rfPrescaleSel);
  endtask
  // Synchronous then asynchronous power-down
  task automatic t_powerdown();
    load(div_word(1'b0, 1'b1, 2'h0, 12'h001, 6'h01), 0);
    compare("powerdown", 24'h1, rfPowerdown);
    compare("tristate", 24'h1, rfPumpTristate);
    load(div_word(1'b0, 1'b0, 2'h0, 12'h001, 6'h01), 0);
    compare("powerdown", 24'h0, rfPowerdown);
    load(24'h44000E, 0);
    compare("tristate", 24'h1, rfPumpTristate);
    compare("current", 24'h2, rfPumpCurrent);
    load(div_word(1'b0, 1'b1, 2'h0, 12'h001, 6'h01), 0);
    compare("powerdown", 24'h1, rfPowerdown);
  endtask
  // Extra leading clocks drop out of the input register
  task automatic t_extra_bits();
    load(24'h123450, 5);
    compare("ifref", 24'h123450, ifRefWord);
  endtask
  // Hang guard
  initial begin
    #400us;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    t_power_up();
    t_fast_lock();
    t_powerdown();
    t_extra_bits();
    finish_test();
  end
endmodule
`default_nettype wire
